// ### pci_master_write_width_fallback_tb.sv
// Purpose: self-checking bench for the write fallback block
// Assumes: bench acts as local master and address-phase source
// Notes: monitor pops expected words from a queue as they appear
`timescale 1ns/1ps
`include "pwf_defines.svh"
module pci_master_write_width_fallback_tb;
	import pwf_pkg::*;
	logic sys_clk = 0, nrst = 0, addr_phase = 0, slow = 0;
	logic local_wide_request_n = 1, local_source_ready_n = 1;
	logic [31:0] start_addr = '0;
	logic [3:0] command = 4'h7;
	logic [63:0] local_data_in = '0;
	logic [7:0] local_byte_enables_in = '0;
	pwf_pci_in_t pin;
	logic framen, irdyn, reqn, ad_oe, local_grant_n, strobe_n, low_n, high_n, wide_n;
	logic [63:0] ad_out;
	logic [7:0] cben_out;
	logic [3:0] cnt, state, cnt_prev = '0;
	logic armed = 0;
	logic [71:0] exp_q[$];
	integer seed = 42, bad_count = 0, num_checks = 0, cycles = 0, n;
	always #2.5 sys_clk = ~sys_clk;
	pwf_master_write u_pwf_master_write (.sys_clk(sys_clk), .nrst(nrst),
		.addr_phase(addr_phase), .start_addr(start_addr), .command(command),
		.local_wide_request_n(local_wide_request_n), .local_source_ready_n(local_source_ready_n),
		.local_data_in(local_data_in), .local_byte_enables_in(local_byte_enables_in),
		.gntn_pin(pin.gntn), .devseln_pin(pin.devseln), .trdyn_pin(pin.trdyn),
		.ack64n_pin(pin.ack64n), .framen(framen), .irdyn(irdyn), .reqn(reqn), .ad_out(ad_out),
		.cben_out(cben_out), .ad_oe(ad_oe), .local_grant_n(local_grant_n),
		.local_low_word_strobe_n(strobe_n), .local_low_word_taken_n(low_n),
		.local_high_word_taken_n(high_n), .local_wide_transfer_flag_n(wide_n),
		.local_phase_counter(cnt), .local_master_state(state));
	pwf_far_model u_pwf_far_model (.sys_clk(sys_clk), .nrst(nrst), .slow(slow), .reqn(reqn),
		.framen(framen), .irdyn(irdyn), .pin(pin));
	task automatic check(input logic [71:0] got, input logic [71:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// Output monitor
	// ----------------------------------------
	always @(negedge sys_clk) begin
		if (armed || (cnt_prev === 4'h2 && cnt === 4'h1)) begin
			if (exp_q.size() == 0) check(72'h1, 72'h0);
			// words in order on the bus
			else if (armed) check({cben_out, ad_out}, exp_q.pop_front());
			else check({40'h0, cben_out[3:0], ad_out[31:0]}, exp_q.pop_front());
		end
		armed = (strobe_n === 1'b0);
		if (strobe_n === 1'b0) check({low_n, high_n}, 72'h0);
		cnt_prev = cnt;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles >= 4000) begin
			bad_count++;
			finish_test;
		end
	end
	task run_write(input logic s);
		logic [63:0] d;
		logic [7:0] be;
		d = {$random(seed), $random(seed)};
		be = 8'($random(seed));
		exp_q.push_back({be, d});
		exp_q.push_back({40'h0, be[7:4], d[63:32]});
		@(posedge sys_clk);
		slow <= s;
		addr_phase <= 1'b1;
		start_addr <= $random(seed);
		local_wide_request_n <= 1'b0;
		local_source_ready_n <= 1'b0;
		local_data_in <= d;
		local_byte_enables_in <= be;
		@(posedge sys_clk);
		// On slow runs addr_phase is held high a second cycle while busy and must be ignored
		addr_phase <= s;
		local_wide_request_n <= 1'b1;
		@(negedge sys_clk);
		check({cben_out, ad_out}, {4'h0, command, 32'h0, start_addr});
		check({state, reqn, framen, cnt}, {`PWF_ST_ADDR, 2'b00, `PWF_BURST_ONE});
		@(posedge sys_clk);
		addr_phase <= 1'b0;
		n = 0;
		while (cnt !== 4'h2 && n < 40) begin @(negedge sys_clk); n++; end
		check({wide_n, reqn, framen, local_grant_n, cnt}, {4'b1100, 4'h2});
		n = 0;
		while (irdyn !== 1'b0 && n < 20) begin @(negedge sys_clk); n++; end
		check(n < 20, 72'h1);
		n = 0;
		while (state !== 4'h0 && n < 40) begin @(negedge sys_clk); n++; end
		check({framen, irdyn, ad_oe, cnt}, {3'b110, 4'h0});
		@(posedge sys_clk);
		local_source_ready_n <= 1'b1;
		repeat (6) @(negedge sys_clk);
		check(local_grant_n, 72'h1);
	endtask : run_write
	initial begin
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int t = 0; t < 6; t++) begin
			run_write(t[0]);
			$display("test %0d done", t);
		end
		check(exp_q.size(), 72'h0);
		finish_test;
	end
endmodule : pci_master_write_width_fallback_tb

// ### pwf_defines.svh
// Purpose: constants for the wide-to-narrow write fallback block
// Assumes: one clock, active-low PCI style signalling
// Notes: definitions only
`ifndef PWF_DEFINES_SVH
`define PWF_DEFINES_SVH
`define PWF_CNT_W 4
`define PWF_BURST_TWO 4'h2
`define PWF_BURST_ONE 4'h1
`define PWF_BURST_ZERO 4'h0
`define PWF_STATE_W 4
`define PWF_ST_IDLE 4'h0
`define PWF_ST_ADDR 4'h6
`define PWF_ST_WAIT 4'h7
`define PWF_ST_DATA 4'h8
`endif

// ### pwf_far_model.sv
// Purpose: arbiter and narrow PCI target facing the write fallback block
// Assumes: one clock; target lines pulled up when released
// Notes: slow inserts ready wait states on the first phase; devseln timing is the same either way
`timescale 1ns/1ps
module pwf_far_model
	import pwf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic reqn,
	input wire logic framen,
	input wire logic irdyn,
	output pwf_pci_in_t pin
);
	logic busy_reg;
	logic [2:0] wait_reg;
	// ----------------------------------------
	// Target behaviour
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin <= '1;
			busy_reg <= 1'b0;
			wait_reg <= 3'h0;
		end else begin
			pin.ack64n <= 1'b1;
			// Grant simply mirrors the request
			pin.gntn <= reqn;
			if (!framen && !busy_reg) begin
				busy_reg <= 1'b1;
				wait_reg <= slow ? 3'h4 : 3'h0;
			// release only once master ends the phase
			end else if (busy_reg && framen && irdyn) begin
				busy_reg <= 1'b0;
				pin.devseln <= 1'b1;
				pin.trdyn <= 1'b1;
			end else if (busy_reg) begin
				pin.devseln <= 1'b0;
				pin.trdyn <= (wait_reg != 3'h0);
				if (wait_reg != 3'h0) begin
					wait_reg <= wait_reg - 3'h1;
				end
			end
		end
	end
endmodule : pwf_far_model

// ### pwf_master_write.sv
// Purpose: run a local 64-bit write as a two-phase 32-bit burst when the
//   target answers without ack64n
// Assumes: address phase driven by the caller via addr_phase pulse
// Notes: PCI inputs are synchronised by two flops before use
//
// Contract
// - Deassert reqn the cycle after framen asserted with wide request deasserted.
// - After both strobes in address phase, drive both words on full ad/cben.
// - Local grant follows PCI grant and drops when it drops.
// - On 32-bit answer clear wide flag, set burst count two, burst.
// - devseln and local ready last cycle: assert irdyn for 32-bit burst.
// - Hold framen asserted during the burst until its final data phase.
// - A data phase completes only when irdyn and trdyn both asserted.
// - Decrement burst count the cycle after each completed data phase.
// - After first word taken, put second word on low ad and cben.
// - Local ready last cycle keeps irdyn asserted for next phase.
// - Master gives two words and enables; device asserts both strobes.
`timescale 1ns/1ps
`include "pwf_defines.svh"
module pwf_master_write
	import pwf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic addr_phase,
	input wire logic [31:0] start_addr,
	input wire logic [3:0] command,
	input wire logic local_wide_request_n,
	input wire logic local_source_ready_n,
	input wire logic [63:0] local_data_in,
	input wire logic [7:0] local_byte_enables_in,
	input wire logic gntn_pin,
	input wire logic devseln_pin,
	input wire logic trdyn_pin,
	input wire logic ack64n_pin,
	output logic framen,
	output logic irdyn,
	output logic reqn,
	output logic [63:0] ad_out,
	output logic [7:0] cben_out,
	output logic ad_oe,
	output logic local_grant_n,
	output logic local_low_word_strobe_n,
	output logic local_low_word_taken_n,
	output logic local_high_word_taken_n,
	output logic local_wide_transfer_flag_n,
	output logic [`PWF_CNT_W-1:0] local_phase_counter,
	output logic [`PWF_STATE_W-1:0] local_master_state
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	pwf_pci_in_t meta_reg;
	pwf_pci_in_t pin_reg;
	pwf_pci_in_t pin_now;
	assign pin_now = '{gntn: gntn_pin, devseln: devseln_pin, trdyn: trdyn_pin,
		ack64n: ack64n_pin};

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= '1;
			pin_reg <= '1;
		end else begin
			meta_reg <= pin_now;
			pin_reg <= meta_reg;
		end
	end

	// ----------------------------------------
	// State and datapath registers
	// ----------------------------------------
	pwf_state_t state_reg, state_next;
	pwf_pci_out_t pci_reg, pci_next;
	logic [31:0] hi_word_reg, hi_word_next;
	logic [3:0] hi_be_reg, hi_be_next;
	logic [`PWF_CNT_W-1:0] cnt_reg, cnt_next;
	logic wide_n_reg, wide_n_next;
	logic strobes_reg, strobes_next;
	logic rdy_prev_reg;
	logic req64_prev_reg;
	logic gnt_reg;

	function automatic logic [`PWF_STATE_W-1:0] state_code(input pwf_state_t s);
		case (s)
			PWF_ADDR: state_code = `PWF_ST_ADDR;
			PWF_WAIT: state_code = `PWF_ST_WAIT;
			PWF_DATA1, PWF_DATA2, PWF_DONE: state_code = `PWF_ST_DATA;
			default: state_code = `PWF_ST_IDLE;
		endcase
	endfunction : state_code

	// Data phase done only on both ready strobes
	// phase completion
	wire phase_done = !pci_reg.irdyn && !pin_reg.trdyn;
	wire narrow_ack = !pin_reg.devseln && pin_reg.ack64n;
	wire final_phase = (cnt_reg == `PWF_BURST_ONE);

	always_comb begin
		state_next = state_reg;
		pci_next = pci_reg;
		hi_word_next = hi_word_reg;
		hi_be_next = hi_be_reg;
		cnt_next = cnt_reg;
		wide_n_next = wide_n_reg;
		strobes_next = 1'b1;
		if (!pci_reg.framen && req64_prev_reg) begin
			pci_next.reqn = 1'b1;
		end
		case (state_reg)
			PWF_IDLE: begin
				pci_next = '{framen: 1'b1, irdyn: 1'b1, reqn: 1'b1,
					ad: 64'h0, cben: 8'h0, ad_oe: 1'b0};
				if (addr_phase) begin
					pci_next.framen = 1'b0;
					pci_next.reqn = 1'b0;
					pci_next.ad = {32'h0, start_addr};
					pci_next.cben = {4'h0, command};
					pci_next.ad_oe = 1'b1;
					wide_n_next = local_wide_request_n;
					cnt_next = `PWF_BURST_ONE;
					strobes_next = local_source_ready_n;
					state_next = PWF_ADDR;
				end
			end
			PWF_ADDR: begin
				if (!strobes_reg) begin
					pci_next.ad = local_data_in;
					pci_next.cben = local_byte_enables_in;
					hi_word_next = local_data_in[63:32];
					hi_be_next = local_byte_enables_in[7:4];
				end
				state_next = PWF_WAIT;
			end
			PWF_WAIT: begin
				if (narrow_ack) begin
					wide_n_next = 1'b1;
					cnt_next = `PWF_BURST_TWO;
				end
				if (!pin_reg.devseln && rdy_prev_reg) begin
					pci_next.irdyn = 1'b0;
					state_next = PWF_DATA1;
				end
			end
			PWF_DATA1: begin
				pci_next.framen = 1'b0;
				if (phase_done) begin
					pci_next.ad = {32'h0, hi_word_reg};
					pci_next.cben = {4'h0, hi_be_reg};
					pci_next.irdyn = !rdy_prev_reg;
					state_next = PWF_DATA2;
				end
			end
			PWF_DATA2: begin
				pci_next.irdyn = pci_reg.irdyn && !rdy_prev_reg;
				pci_next.framen = final_phase;
				if (phase_done) begin
					pci_next.irdyn = 1'b1;
					pci_next.framen = 1'b1;
					state_next = PWF_DONE;
				end
			end
			PWF_DONE: begin
				pci_next.ad_oe = 1'b0;
				state_next = PWF_IDLE;
			end
			default: state_next = PWF_IDLE;
		endcase
		if (phase_done && cnt_reg != `PWF_BURST_ZERO) begin
			cnt_next = cnt_reg - `PWF_BURST_ONE;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= PWF_IDLE;
			pci_reg <= '{framen: 1'b1, irdyn: 1'b1, reqn: 1'b1,
				ad: 64'h0, cben: 8'h0, ad_oe: 1'b0};
			hi_word_reg <= 32'h0;
			hi_be_reg <= 4'h0;
			cnt_reg <= `PWF_BURST_ZERO;
			wide_n_reg <= 1'b1;
			strobes_reg <= 1'b1;
			rdy_prev_reg <= 1'b0;
			req64_prev_reg <= 1'b0;
			gnt_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			pci_reg <= pci_next;
			hi_word_reg <= hi_word_next;
			hi_be_reg <= hi_be_next;
			cnt_reg <= cnt_next;
			wide_n_reg <= wide_n_next;
			strobes_reg <= strobes_next;
			rdy_prev_reg <= !local_source_ready_n;
			req64_prev_reg <= local_wide_request_n;
			gnt_reg <= pin_reg.gntn;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic [`PWF_STATE_W-1:0] status_reg;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			status_reg <= `PWF_ST_IDLE;
		end else begin
			status_reg <= state_code(state_next);
		end
	end

	assign framen = pci_reg.framen;
	assign irdyn = pci_reg.irdyn;
	assign reqn = pci_reg.reqn;
	assign ad_out = pci_reg.ad;
	assign cben_out = pci_reg.cben;
	assign ad_oe = pci_reg.ad_oe;
	assign local_grant_n = gnt_reg;
	assign local_low_word_strobe_n = strobes_reg;
	assign local_low_word_taken_n = strobes_reg;
	assign local_high_word_taken_n = strobes_reg;
	assign local_wide_transfer_flag_n = wide_n_reg;
	assign local_phase_counter = cnt_reg;
	assign local_master_state = status_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_narrow_seen;
		state_reg == PWF_WAIT && narrow_ack;
	endsequence

	property p_req_release;
		@(posedge sys_clk) disable iff (!nrst)
		(!pci_reg.framen && req64_prev_reg) |=> pci_reg.reqn;
	endproperty
	a_req_release: assert property (p_req_release) else $error("reqn not released");

	property p_wide_drive;
		@(posedge sys_clk) disable iff (!nrst)
		(state_reg == PWF_ADDR && !strobes_reg)
			|=> (ad_out == $past(local_data_in) && cben_out == $past(local_byte_enables_in));
	endproperty
	a_wide_drive: assert property (p_wide_drive) else $error("wide data not driven");

	property p_grant_follow;
		@(posedge sys_clk) disable iff (!nrst)
		pin_reg.gntn |=> local_grant_n;
	endproperty
	a_grant_follow: assert property (p_grant_follow) else $error("grant not followed");

	property p_fallback;
		@(posedge sys_clk) disable iff (!nrst)
		s_narrow_seen |=> (local_wide_transfer_flag_n && local_phase_counter == `PWF_BURST_TWO);
	endproperty
	a_fallback: assert property (p_fallback) else $error("burst fallback missing");

	property p_irdy_start;
		@(posedge sys_clk) disable iff (!nrst)
		(state_reg == PWF_WAIT && !pin_reg.devseln && rdy_prev_reg) |=> !irdyn;
	endproperty
	a_irdy_start: assert property (p_irdy_start) else $error("irdyn not asserted");

	property p_frame_hold;
		@(posedge sys_clk) disable iff (!nrst)
		(state_reg == PWF_DATA1) |-> !framen;
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("framen dropped in burst");

	property p_count_dec;
		@(posedge sys_clk) disable iff (!nrst)
		(phase_done && state_reg != PWF_WAIT && cnt_reg != `PWF_BURST_ZERO)
			|=> (cnt_reg == $past(cnt_reg) - `PWF_BURST_ONE);
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("count not decremented");

	property p_second_word;
		@(posedge sys_clk) disable iff (!nrst)
		(state_reg == PWF_DATA1 && phase_done)
			|=> (ad_out[31:0] == hi_word_reg && cben_out[3:0] == hi_be_reg);
	endproperty
	a_second_word: assert property (p_second_word) else $error("second word misplaced");

	property p_grant_low;
		@(posedge sys_clk) disable iff (!nrst)
		!pin_reg.gntn |=> !local_grant_n;
	endproperty
	a_grant_low: assert property (p_grant_low) else $error("grant low not followed");

	property p_irdy_keep;
		@(posedge sys_clk) disable iff (!nrst)
		(((state_reg == PWF_DATA1 && phase_done) || (state_reg == PWF_DATA2 && !phase_done))
			&& rdy_prev_reg) |=> !irdyn;
	endproperty
	a_irdy_keep: assert property (p_irdy_keep) else $error("irdyn not kept");

	property p_frame_end;
		@(posedge sys_clk) disable iff (!nrst)
		(state_reg == PWF_DATA2 && final_phase) |=> framen;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("framen not ended");

	property p_count_hold;
		@(posedge sys_clk) disable iff (!nrst)
		(state_reg != PWF_IDLE && state_reg != PWF_WAIT && !phase_done) |=> $stable(cnt_reg);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("count moved without phase");

endmodule : pwf_master_write

// ### pwf_pkg.sv
// Purpose: types for the wide-to-narrow write fallback block
// Assumes: constants come from pwf_defines.svh
// Notes: carriers group PCI output and PCI input signals
`include "pwf_defines.svh"
package pwf_pkg;
	typedef enum {PWF_IDLE, PWF_ADDR, PWF_WAIT, PWF_DATA1, PWF_DATA2, PWF_DONE} pwf_state_t;
	typedef struct packed {
		logic framen;
		logic irdyn;
		logic reqn;
		logic [63:0] ad;
		logic [7:0] cben;
		logic ad_oe;
	} pwf_pci_out_t;
	typedef struct packed {
		logic gntn;
		logic devseln;
		logic trdyn;
		logic ack64n;
	} pwf_pci_in_t;
endpackage : pwf_pkg
